// *** lpil_top.sv ***
// light and proximity measurement sequencer with interrupt logic
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
//
// Contract
// RULE_01: light and proximity converters run concurrently and independently.
// RULE_02: the light channel finishes one conversion every 100 ms while enabled.
// RULE_03: during each proximity conversion the led sink driver is on and the reflection is digitised.
// RULE_04: a proximity conversion takes 540 us.
// RULE_05: proximity conversions repeat with a period of at most 800 ms.
// RULE_06: a light result below the low bound or above the high bound is a light trigger.
// RULE_07: a proximity result above the threshold is a proximity trigger.
// RULE_08: a channel interrupt needs 1, 4, 8 or 16 consecutive triggers; a miss restarts the count.
// RULE_09: an option asserts the pin only when both conditions hold together, up to 16 times in a row.
// RULE_10: every interrupt event sets a status bit and drives the interrupt pin; pin only for unmasked joint events in both mode, else unmasked channel ones
// RULE_11: the interrupt pin is active low open drain, pulled low while pending.
// RULE_12: light results are 12 bits saturating at 4095, proximity 8 bits saturating at 255.
// RULE_13: separate enables; both cleared stops all conversion and powers down.
// RULE_14: the host reaches results, status and settings by bus accesses; a select pin sets one address bit.
// RULE_15: the host clears a pending interrupt through the status bits, releasing the pin.
module lpil_top #(
  parameter int unsigned ALS_PERIOD = lpil_pkg::ALS_PERIOD_CYC,
  parameter int unsigned PROX_CONV = lpil_pkg::PROX_CONV_CYC,
  parameter int unsigned PROX_PERIOD = lpil_pkg::PROX_PERIOD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] als_sample,
  input wire logic [15:0] prox_sample,
  input wire logic bus_target_select,
  output logic [6:0] bus_target_addr,
  output logic led_sink_driver,
  output logic int_n_o,
  output logic int_n_oe,
  output logic powered_down
);
  import lpil_pkg::*;

  // persistence code to trigger count 1/4/8/16
  function automatic logic [4:0] pers_count(input logic [1:0] code);
    unique case (code)
      2'd0: pers_count = 5'd1;
      2'd1: pers_count = 5'd4;
      2'd2: pers_count = 5'd8;
      2'd3: pers_count = 5'd16;
    endcase
  endfunction : pers_count

  // clamp a raw converter value to a result width
  function automatic logic [15:0] sat(input logic [15:0] v, input logic [15:0] mx);
    sat = (v > mx) ? mx : v;
  endfunction : sat

  // software registers and their next values
  logic [31:0] ctrl, next_ctrl;
  logic [11:0] als_lo, next_als_lo, als_hi, next_als_hi;
  logic [7:0] prox_th, next_prox_th;
  logic [2:0] status, next_status, mask, next_mask;
  logic [11:0] als_data, next_als_data;
  logic [7:0] prox_data, next_prox_data;
  // conversion timers and the proximity sequencer
  logic [31:0] als_cnt, next_als_cnt, px_cnt, next_px_cnt, px_per, next_px_per;
  lpil_px_t px_state, next_px_state;
  // consecutive trigger counts and the latest trigger of each channel
  logic [4:0] als_pc, next_als_pc, px_pc, next_px_pc, both_pc, next_both_pc;
  logic als_hold, next_als_hold, px_hold, next_px_hold;
  // next values of the registered outputs
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_led, next_int_n_oe, next_pd;
  logic [6:0] next_addr;
  // control fields and bus strobes
  logic als_en, prox_en, and_mode, wr, rd;

  assign als_en = ctrl[CTRL_ALS_EN];
  assign prox_en = ctrl[CTRL_PROX_EN];
  assign and_mode = ctrl[CTRL_AND_MODE];
  assign wr = psel & penable & pwrite & pready;
  assign rd = psel & penable & ~pwrite;

  // measurement sequencing, triggers, persistence and registers
  always_comb begin
    // strobes and triggers that live for this cycle only
    logic als_done, px_done, als_trig, px_trig, ev_als, ev_px, ev_both;
    logic [2:0] set_bits;
    logic [15:0] a_v, p_v;
    als_done = 1'b0;
    px_done = 1'b0;
    als_trig = 1'b0;
    px_trig = 1'b0;
    ev_als = 1'b0;
    ev_px = 1'b0;
    ev_both = 1'b0;
    set_bits = 3'b000;
    a_v = sat(als_sample, {4'h0, ALS_MAX}); // RULE_12
    p_v = sat(prox_sample, {8'h00, PROX_MAX}); // RULE_12
    next_ctrl = ctrl;
    next_als_lo = als_lo;
    next_als_hi = als_hi;
    next_prox_th = prox_th;
    next_mask = mask;
    next_als_data = als_data;
    next_prox_data = prox_data;
    next_als_cnt = als_cnt;
    next_px_cnt = px_cnt;
    next_px_per = px_per;
    next_px_state = px_state;
    next_als_pc = als_pc;
    next_px_pc = px_pc;
    next_both_pc = both_pc;
    next_als_hold = als_hold;
    next_px_hold = px_hold;
    // light converter, independent of the proximity one
    if (als_en) begin // RULE_01
      if (als_cnt >= ALS_PERIOD - 1) begin // RULE_02
        next_als_cnt = 32'd0;
        als_done = 1'b1;
        next_als_data = a_v[11:0];
        als_trig = (a_v[11:0] < als_lo) || (a_v[11:0] > als_hi); // RULE_06
      end else begin
        next_als_cnt = als_cnt + 32'd1;
      end
    end else begin
      next_als_cnt = 32'd0; // RULE_13
    end
    // proximity converter: led pulse for the conversion, then wait out the period
    next_px_per = (px_per >= PROX_PERIOD - 1) ? 32'd0 : px_per + 32'd1; // RULE_05
    unique case (px_state)
      PX_IDLE: begin
        next_px_cnt = 32'd0;
        next_px_per = 32'd0;
        if (prox_en) begin
          next_px_state = PX_CONV;
        end
      end
      PX_CONV: begin
        next_px_cnt = px_cnt + 32'd1;
        if (!prox_en) begin
          next_px_state = PX_IDLE; // RULE_13
        end else if (px_cnt >= PROX_CONV - 1) begin // RULE_04
          px_done = 1'b1;
          next_prox_data = p_v[7:0]; // RULE_03
          px_trig = p_v[7:0] > prox_th; // RULE_07
          next_px_state = PX_WAIT;
        end
      end
      PX_WAIT: begin
        next_px_cnt = 32'd0;
        if (!prox_en) begin
          next_px_state = PX_IDLE;
        end else if (px_per >= PROX_PERIOD - 1) begin // RULE_05
          next_px_state = PX_CONV;
        end
      end
      default: next_px_state = PX_IDLE;
    endcase
    // consecutive trigger counting per channel; a miss restarts
    if (als_done) begin // RULE_08
      next_als_pc = als_trig ? ((als_pc < 5'd16) ? als_pc + 5'd1 : als_pc) : 5'd0;
      next_als_hold = als_trig;
      ev_als = als_trig && (next_als_pc == pers_count(ctrl[CTRL_ALS_PERS +: 2]));
    end
    if (px_done) begin // RULE_08
      next_px_pc = px_trig ? ((px_pc < 5'd16) ? px_pc + 5'd1 : px_pc) : 5'd0;
      next_px_hold = px_trig;
      ev_px = px_trig && (next_px_pc == pers_count(ctrl[CTRL_PROX_PERS +: 2]));
    end
    // both-channels condition counted at each completed conversion
    if (als_done || px_done) begin // RULE_09
      if (next_als_hold && next_px_hold) begin
        next_both_pc = (both_pc < 5'd16) ? both_pc + 5'd1 : both_pc;
        ev_both = (next_both_pc == pers_count(ctrl[CTRL_AND_PERS +: 2]));
      end else begin
        next_both_pc = 5'd0;
      end
    end
    if (!als_en) begin
      next_als_pc = 5'd0;
      next_als_hold = 1'b0;
    end
    if (!prox_en) begin
      next_px_pc = 5'd0;
      next_px_hold = 1'b0;
    end
    set_bits[ST_ALS] = ev_als; // RULE_10
    set_bits[ST_PROX] = ev_px;
    set_bits[ST_BOTH] = ev_both;
    // register writes; status is write one to clear with set winning
    next_status = status | set_bits;
    if (wr) begin // RULE_14
      unique case (paddr)
        OFF_CTRL: next_ctrl = {22'h0, pwdata[9:0]};
        OFF_ALS_LO: next_als_lo = pwdata[11:0];
        OFF_ALS_HI: next_als_hi = pwdata[11:0];
        OFF_PROX_TH: next_prox_th = pwdata[7:0];
        OFF_STATUS: next_status = (status & ~pwdata[2:0]) | set_bits; // RULE_15
        OFF_MASK: next_mask = pwdata[2:0];
        default: ;
      endcase
    end
    // read data and bus answer, one wait state
    next_pready = psel & penable & ~pready;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (psel && penable && !pready) begin
      next_pslverr = paddr > OFF_PROX_DATA || paddr[1:0] != 2'b00;
      unique case (paddr)
        OFF_CTRL: next_prdata = ctrl;
        OFF_ALS_LO: next_prdata = {20'h0, als_lo};
        OFF_ALS_HI: next_prdata = {20'h0, als_hi};
        OFF_PROX_TH: next_prdata = {24'h0, prox_th};
        OFF_STATUS: next_prdata = {29'h0, status};
        OFF_MASK: next_prdata = {29'h0, mask};
        OFF_ALS_DATA: next_prdata = {20'h0, als_data};
        OFF_PROX_DATA: next_prdata = {24'h0, prox_data};
        default: next_prdata = 32'h0000_0000;
      endcase
      if (!pwrite) begin
        next_pslverr = next_pslverr & rd;
      end
    end
    next_led = (next_px_state == PX_CONV); // RULE_03
    // in both mode only the joint event reaches the pin
    if (and_mode) begin // RULE_09
      next_int_n_oe = ~(next_status[ST_BOTH] & next_mask[ST_BOTH]); // RULE_11
    end else begin
      next_int_n_oe = ~|(next_status[1:0] & next_mask[1:0]); // RULE_11
    end
    next_pd = ~(next_ctrl[CTRL_ALS_EN] | next_ctrl[CTRL_PROX_EN]); // RULE_13
    next_addr = {BUS_ADDR_BASE[6:1], bus_target_select}; // RULE_14
  end

  // all state and outputs registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      als_lo <= ALS_LO_RST;
      als_hi <= ALS_HI_RST;
      prox_th <= PROX_TH_RST;
      status <= 3'h0;
      mask <= MASK_RST;
      als_data <= 12'h0_000;
      prox_data <= 8'h00;
      als_cnt <= 32'h0000_0000;
      px_cnt <= 32'h0000_0000;
      px_per <= 32'h0000_0000;
      px_state <= PX_IDLE;
      als_pc <= 5'h00;
      px_pc <= 5'h00;
      both_pc <= 5'h00;
      als_hold <= 1'b0;
      px_hold <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      led_sink_driver <= 1'b0;
      int_n_oe <= 1'b1;
      powered_down <= 1'b1;
      bus_target_addr <= 7'h00;
    end else begin
      ctrl <= next_ctrl;
      als_lo <= next_als_lo;
      als_hi <= next_als_hi;
      prox_th <= next_prox_th;
      status <= next_status;
      mask <= next_mask;
      als_data <= next_als_data;
      prox_data <= next_prox_data;
      als_cnt <= next_als_cnt;
      px_cnt <= next_px_cnt;
      px_per <= next_px_per;
      px_state <= next_px_state;
      als_pc <= next_als_pc;
      px_pc <= next_px_pc;
      both_pc <= next_both_pc;
      als_hold <= next_als_hold;
      px_hold <= next_px_hold;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      led_sink_driver <= next_led;
      int_n_oe <= next_int_n_oe;
      powered_down <= next_pd;
      bus_target_addr <= next_addr;
    end
  end

  // open drain pin only ever drives low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_n_o <= 1'b0;
    end else begin
      int_n_o <= 1'b0; // RULE_11
    end
  end
endmodule : lpil_top

// *** lpil_pkg.sv ***
// package of constants for the light and proximity interrupt logic
package lpil_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ALS_PERIOD_MS = 100;
  localparam int unsigned PROX_CONV_US = 540;
  localparam int unsigned PROX_PERIOD_MS = 800;
  localparam int unsigned ALS_PERIOD_CYC = ALS_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned PROX_CONV_CYC = PROX_CONV_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PROX_PERIOD_CYC = PROX_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned ALS_W = 12;
  localparam int unsigned PROX_W = 8;
  localparam logic [11:0] ALS_MAX = 12'h0_FFF;
  localparam logic [7:0] PROX_MAX = 8'h00_FF;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ALS_LO = 8'h04;
  localparam logic [7:0] OFF_ALS_HI = 8'h08;
  localparam logic [7:0] OFF_PROX_TH = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_ALS_DATA = 8'h18;
  localparam logic [7:0] OFF_PROX_DATA = 8'h1C;
  // control field positions
  localparam int unsigned CTRL_ALS_EN = 0;
  localparam int unsigned CTRL_PROX_EN = 1;
  localparam int unsigned CTRL_AND_MODE = 2;
  localparam int unsigned CTRL_ALS_PERS = 4;
  localparam int unsigned CTRL_PROX_PERS = 6;
  localparam int unsigned CTRL_AND_PERS = 8;
  // status field positions
  localparam int unsigned ST_ALS = 0;
  localparam int unsigned ST_PROX = 1;
  localparam int unsigned ST_BOTH = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [11:0] ALS_LO_RST = 12'h0_000;
  localparam logic [11:0] ALS_HI_RST = 12'h0_FFF;
  localparam logic [7:0] PROX_TH_RST = 8'h00_FF;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [7:0] BUS_ADDR_BASE = 8'h00_44;
  typedef enum logic [1:0] {
    PX_IDLE = 2'b00,
    PX_CONV = 2'b01,
    PX_WAIT = 2'b10
  } lpil_px_t;
endpackage : lpil_pkg

// *** lpil_checker.sv ***
// assertion checker for the light and proximity interrupt logic
`timescale 1ns/1ps
module lpil_checker #(
  parameter int unsigned PROX_CONV = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_target_select,
  input wire logic [6:0] bus_target_addr,
  input wire logic led_sink_driver,
  input wire logic int_n_o,
  input wire logic int_n_oe,
  input wire logic powered_down
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [31:0] led_cnt;
  logic [31:0] next_led_cnt;
  logic ctrl_wr;
  logic mask_clr;
  // cycles the led has been on so far
  always_comb next_led_cnt = led_sink_driver ? led_cnt + 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      led_cnt <= 32'h0000_0000;
    else
      led_cnt <= next_led_cnt;
  end
  assign ctrl_wr = psel && penable && pready && pwrite && paddr == lpil_pkg::OFF_CTRL;
  // a completed write that clears every mask bit
  assign mask_clr = psel && penable && pready && pwrite && paddr == lpil_pkg::OFF_MASK && pwdata[2:0] == 3'b000;
  // handshake, pin and sequencing relations
  AST_ANSWER: assert property (psel && penable && !pready |=> pready) else $error("late answer");
  AST_READY_CAUSE: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
  AST_ERR_PAIRED: assert property (pslverr |-> pready) else $error("lone error");
  AST_ADDR_PIN: assert property ($past(presetn) |->
    bus_target_addr == {lpil_pkg::BUS_ADDR_BASE[6:1], $past(bus_target_select)}) else $error("bad address");
  AST_INT_DRIVE: assert property (!int_n_oe |-> !int_n_o) else $error("pin not low");
  AST_INT_MASKED: assert property (mask_clr |=> int_n_oe) else $error("pin held while masked");
  // a conversion cut short by a disabling control write is exempt from the width check
  AST_LED_WIDTH: assert property ($fell(led_sink_driver) && !$past(ctrl_wr, 2) |->
    led_cnt == PROX_CONV) else $error("led width");
  AST_PD_SET: assert property (ctrl_wr && pwdata[1:0] == 2'b00 |-> ##[1:2] powered_down) else $error("no sleep");
  AST_PD_CLR: assert property (ctrl_wr && pwdata[1:0] != 2'b00 |-> ##[1:2] !powered_down) else $error("no wake");
  // main scenarios reached
  cover property ($fell(int_n_oe));
  cover property (pslverr);
  cover property ($fell(led_sink_driver));
endmodule : lpil_checker

// *** lpil_host_pin.sv ***
// host side of the interrupt line: open drain with a pull-up
`timescale 1ns/1ps
module lpil_host_pin (
  input wire logic int_n_o,
  input wire logic int_n_oe,
  output logic int_line
);
  // pull-up wins while the device lets go of the pin
  assign int_line = int_n_oe ? 1'b1 : int_n_o;
endmodule : lpil_host_pin

// *** light_proximity_interrupt_logic_tb.sv ***
// testbench for the light and proximity interrupt logic
`timescale 1ns/1ps
module light_proximity_interrupt_logic_tb;
  import lpil_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bus_target_select = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic [15:0] als_sample = 16'h0000, prox_sample = 16'h0000;
  logic pready, pslverr, rerr, led_sink_driver, int_n_o, int_n_oe, powered_down, int_line;
  logic [6:0] bus_target_addr;
  int error_cnt = 0, num_checks = 0, cyc = 0, n;
  // 100 MHz clock
  always #5 pclk = ~pclk;
  lpil_top #(.ALS_PERIOD(50), .PROX_CONV(20), .PROX_PERIOD(100)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .als_sample(als_sample), .prox_sample(prox_sample),
    .bus_target_select(bus_target_select), .bus_target_addr(bus_target_addr),
    .led_sink_driver(led_sink_driver), .int_n_o(int_n_o), .int_n_oe(int_n_oe), .powered_down(powered_down));
  lpil_host_pin host (.int_n_o(int_n_o), .int_n_oe(int_n_oe), .int_line(int_line));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer, held until ready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(rdat, exp);
  endtask : rdc
  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask : wt
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  // cycle ceiling against a hung handshake
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    wt(2);
    presetn <= 1'b1;
    // reset values, refused access and address pin
    rdc(OFF_ALS_HI, 32'h0000_0FFF);
    rdc(OFF_PROX_TH, 32'h0000_00FF);
    check(powered_down, 1'b1);
    xfer(1'b0, 8'h20, 32'h0000_0000);
    check(rerr, 1'b1);
    bus_target_select <= 1'b1;
    wt(2);
    check(bus_target_addr, 7'h45);
    $display("test reset done");
    // light window with four triggers, masked then unmasked, then cleared
    xfer(1'b1, OFF_ALS_LO, 32'h0000_0064);
    xfer(1'b1, OFF_ALS_HI, 32'h0000_00C8);
    als_sample <= 16'hFFFF;
    xfer(1'b1, OFF_CTRL, 32'h0000_0011);
    wt(175);
    rdc(OFF_STATUS, 32'h0000_0000);
    wt(50);
    rdc(OFF_STATUS, 32'h0000_0001);
    check(int_line, 1'b1);
    rdc(OFF_ALS_DATA, 32'h0000_0FFF);
    xfer(1'b1, OFF_MASK, 32'h0000_0007);
    wt(2);
    check(int_line, 1'b0);
    als_sample <= 16'h0096;
    wt(60);
    xfer(1'b1, OFF_STATUS, 32'h0000_0001);
    wt(2);
    check(int_line, 1'b1);
    rdc(OFF_STATUS, 32'h0000_0000);
    xfer(1'b1, OFF_CTRL, 32'h0000_0000);
    $display("test light done");
    // proximity persistence for every count, each run ended by a miss, a status clear and a disable
    xfer(1'b1, OFF_PROX_TH, 32'h0000_0032);
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 1 : 2 << c;
      prox_sample <= 16'h0123;
      xfer(1'b1, OFF_CTRL, 32'(c << 6) | 32'h0000_0002);
      wt(100 * (n - 1) + 5);
      rdc(OFF_STATUS, 32'h0000_0000);
      wt(55);
      rdc(OFF_STATUS, 32'h0000_0002);
      check(int_line, 1'b0);
      rdc(OFF_PROX_DATA, 32'h0000_00FF);
      prox_sample <= 16'h000A;
      wt(110);
      xfer(1'b1, OFF_STATUS, 32'h0000_0002);
      xfer(1'b1, OFF_CTRL, 32'h0000_0000);
    end
    $display("test proximity done");
    // both-channel condition, four joint triggers in a row, drives the pin only when both trigger
    xfer(1'b1, OFF_MASK, 32'h0000_0004);
    als_sample <= 16'h0005;
    xfer(1'b1, OFF_CTRL, 32'h0000_0107);
    wt(120);
    rdc(OFF_STATUS, 32'h0000_0001);
    check(int_line, 1'b1);
    prox_sample <= 16'h0123;
    wt(120);
    rdc(OFF_STATUS, 32'h0000_0003);
    check(int_line, 1'b1);
    wt(80);
    rdc(OFF_STATUS, 32'h0000_0007);
    check(int_line, 1'b0);
    // clearing the mask releases the pin while status stays set
    xfer(1'b1, OFF_MASK, 32'h0000_0000);
    wt(2);
    check(int_line, 1'b1);
    $display("test both done");
    end_sim();
  end
endmodule : light_proximity_interrupt_logic_tb
bind lpil_top lpil_checker #(.PROX_CONV(PROX_CONV)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .bus_target_select(bus_target_select), .bus_target_addr(bus_target_addr), .led_sink_driver(led_sink_driver),
  .int_n_o(int_n_o), .int_n_oe(int_n_oe), .powered_down(powered_down));
